// file: scd_pkg.sv
// scd_pkg: shared constants for the clock divider control block
package scd_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_RUN_CFG = 12'h060;
   localparam logic [11:0] ADDR_SEC_CFG = 12'h070;
   localparam logic [11:0] ADDR_STATUS = 12'h074;
   localparam logic [11:0] ADDR_GATE_RUN = 12'h100;
   localparam logic [11:0] ADDR_GATE_SLP = 12'h104;
   localparam logic [11:0] ADDR_GATE_DSL = 12'h108;
   // ------------------------------------------------------------
   // run_clock_config layout
   // ------------------------------------------------------------
   localparam logic [31:0] RUN_RESET = 32'h078e3ac0;
   localparam logic [31:0] RUN_WMASK = 32'h0fde3fff;
   localparam int AUTO_GATE_BIT = 27;
   localparam int SYS_DIVISOR_HI = 26;
   localparam int SYS_DIVISOR_LO = 23;
   localparam int DIV_EN_BIT = 22;
   localparam int PWM_EN_BIT = 20;
   localparam int PWM_DIVISOR_HI = 19;
   localparam int PWM_DIVISOR_LO = 17;
   localparam int BYPASS_BIT = 11;
   // ------------------------------------------------------------
   // second_clock_config layout
   // ------------------------------------------------------------
   localparam logic [31:0] SEC_RESET = 32'h07800000;
   localparam logic [31:0] SEC_WMASK = 32'h87800000;
   localparam int SEC_EN_BIT = 31;
   // ------------------------------------------------------------
   // status layout and misc
   // ------------------------------------------------------------
   localparam int ST_DIV_LO = 0;
   localparam int ST_USE_DIV = 4;
   localparam int ST_PLL = 5;
   localparam int ST_MODE_LO = 6;
   localparam int ST_FREQ_LO = 8;
   localparam logic [7:0] PLL_VCO_MHZ = 8'hc8;
   localparam logic [31:0] GATE_RESET = 32'hffffffff;
   localparam logic [2:0] PWM_LOG_MAX = 3'h6;
   typedef enum logic [1:0] {
      SCD_RUN = 2'b00,
      SCD_SLEEP = 2'b01,
      SCD_DEEP = 2'b10
   } scd_mode_e;
endpackage

// file: scd_pwm_if.sv
// scd_pwm_if: settings and tick between control and pwm predivider
`timescale 1ns/1ps
interface scd_pwm_if;
   logic en;
   logic [2:0] code;
   logic tick;
   modport ctrl (output en, output code, input tick);
   modport div (input en, input code, output tick);
endinterface

// file: scd_pwm_div.sv
// scd_pwm_div: power-of-two pwm clock predivider
`timescale 1ns/1ps
module scd_pwm_div (
   input wire logic clk_sys,
   input wire logic rst,
   scd_pwm_if.div pwm
);
   logic [5:0] cnt_q;
   logic tick_q;
   logic [5:0] mask;

   // codes above /32 all saturate at /64
   function automatic logic [2:0] div_log2(input logic [2:0] c);
      div_log2 = (c < 3'h5) ? c + 3'h1 : scd_pkg::PWM_LOG_MAX;
   endfunction

   // ------------------------------------------------------------
   // free counter
   // ------------------------------------------------------------
   // [RULE11] free power-of-two counter
   // a free counter keeps every ratio aligned to the same edges
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_q <= 6'h00;
      end else begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   always_comb begin
      mask = 6'((7'h01 << div_log2(pwm.code)) - 7'h01);
   end

   // ------------------------------------------------------------
   // tick output
   // ------------------------------------------------------------
   // [RULE10] divide by selected ratio
   // [RULE12] undivided when disabled
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tick_q <= 1'b1;
      end else if (pwm.en) begin
         tick_q <= (cnt_q & mask) == mask;
      end else begin
         tick_q <= 1'b1;
      end
   end
   assign pwm.tick = tick_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   pwm_undiv_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE12]
      !$past(pwm.en) |-> tick_q)
      else $error("pwm tick not undivided");
   // looks back so a later code change cannot trip it
   pwm_half_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE10]
      (pwm.en && pwm.code == 3'h0)[*4] ##0 tick_q |-> !$past(tick_q) && $past(tick_q, 2))
      else $error("pwm divide by two wrong");
endmodule

// file: scd_ctrl.sv
// scd_ctrl: run clock configuration, divisor select and gating control
//
// What this block does
// [RULE1] auto gating set: sleep and deep-sleep use their own gating sets
// [RULE2] run mode uses run gating; sleep too while auto gating clear
// [RULE3] four-bit system divisor at 26:23, reset 0xf, divides pll or osc
// [RULE4] pll source counts as 200 MHz for divisor encodings
// [RULE5] pll in use: divisor below minimum is raised to minimum
// [RULE6] pll unused: programmed divisor applied as written
// [RULE7] divider enable bit selects divider; pll forces divider use
// [RULE8] second config enable takes divisor from second config register
// [RULE9] pwm divider enable at bit 20, reset 0, clocks pwm from divider
// [RULE10] pwm divisor at 19:17, reset 0x7, codes 0-3 give /2../16
// [RULE11] pwm clock is power-of-two division aligned to system edges
// [RULE12] pwm divider disabled: pwm runs on undivided system clock
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module scd_ctrl #(
   parameter int GATE_W = 32,
   parameter logic [3:0] MIN_SYS_DIV = 4'h3,
   parameter logic [7:0] OSC_MHZ = 8'h10
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] pwr_mode,
   output logic [GATE_W-1:0] periph_clk_en,
   output logic [3:0] sys_div_code,
   output logic sys_use_div,
   output logic pll_src,
   output logic [7:0] src_freq_mhz,
   output logic pwm_clk_en,
   output logic pwm_div_on
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [31:0] run_q;
   logic [31:0] sec_q;
   logic [GATE_W-1:0] gate_run_q;
   logic [GATE_W-1:0] gate_slp_q;
   logic [GATE_W-1:0] gate_dsl_q;
   logic [31:0] prdata_q;
   logic [GATE_W-1:0] gate_d;
   logic [GATE_W-1:0] gate_q;
   logic [3:0] div_d;
   logic [3:0] div_q;
   logic use_div_d;
   logic use_div_q;
   logic pll_q;
   logic [7:0] freq_q;
   logic [1:0] mode_q;
   logic wr_acc;
   logic setup;
   logic hit;
   logic pll_used;
   logic auto_gate;
   logic [3:0] prog_div;
   logic [31:0] rd_d;
   logic [31:0] status;
   scd_pwm_if pwm_bus ();

   // byte lanes merged, read-only bits kept at their held value
   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] be,
      input logic [31:0] wm
   );
      logic [31:0] lane;
      lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
      merge = (old & ~lane) | (wd & lane);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == scd_pkg::ADDR_RUN_CFG) || (a == scd_pkg::ADDR_SEC_CFG)
         || (a == scd_pkg::ADDR_STATUS) || (a == scd_pkg::ADDR_GATE_RUN)
         || (a == scd_pkg::ADDR_GATE_SLP) || (a == scd_pkg::ADDR_GATE_DSL);
   endfunction

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   // zero wait states: read data is captured in the setup cycle
   assign setup = psel && !penable;
   assign hit = mapped(paddr);
   assign wr_acc = psel && penable && pwrite && hit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_q;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   // [RULE3] divisor field resets to 0xf
   // [RULE9] pwm enable resets clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         run_q <= scd_pkg::RUN_RESET;
      end else if (wr_acc && paddr == scd_pkg::ADDR_RUN_CFG) begin
         run_q <= merge(run_q, pwdata, pstrb, scd_pkg::RUN_WMASK);
      end
   end

   // [RULE8] second config register storage
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sec_q <= scd_pkg::SEC_RESET;
      end else if (wr_acc && paddr == scd_pkg::ADDR_SEC_CFG) begin
         sec_q <= merge(sec_q, pwdata, pstrb, scd_pkg::SEC_WMASK);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gate_run_q <= GATE_W'(scd_pkg::GATE_RESET);
         gate_slp_q <= GATE_W'(scd_pkg::GATE_RESET);
         gate_dsl_q <= GATE_W'(scd_pkg::GATE_RESET);
      end else if (wr_acc) begin
         if (paddr == scd_pkg::ADDR_GATE_RUN) begin
            gate_run_q <= GATE_W'(merge(32'(gate_run_q), pwdata, pstrb, '1));
         end
         if (paddr == scd_pkg::ADDR_GATE_SLP) begin
            gate_slp_q <= GATE_W'(merge(32'(gate_slp_q), pwdata, pstrb, '1));
         end
         if (paddr == scd_pkg::ADDR_GATE_DSL) begin
            gate_dsl_q <= GATE_W'(merge(32'(gate_dsl_q), pwdata, pstrb, '1));
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_comb begin
      status = 32'h00000000;
      status[scd_pkg::ST_DIV_LO +: 4] = div_q;
      status[scd_pkg::ST_USE_DIV] = use_div_q;
      status[scd_pkg::ST_PLL] = pll_q;
      status[scd_pkg::ST_MODE_LO +: 2] = mode_q;
      status[scd_pkg::ST_FREQ_LO +: 8] = freq_q;
   end

   always_comb begin
      unique case (paddr)
         scd_pkg::ADDR_RUN_CFG: rd_d = run_q;
         scd_pkg::ADDR_SEC_CFG: rd_d = sec_q;
         scd_pkg::ADDR_STATUS: rd_d = status;
         scd_pkg::ADDR_GATE_RUN: rd_d = 32'(gate_run_q);
         scd_pkg::ADDR_GATE_SLP: rd_d = 32'(gate_slp_q);
         scd_pkg::ADDR_GATE_DSL: rd_d = 32'(gate_dsl_q);
         default: rd_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata_q <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata_q <= rd_d;
      end
   end

   // ------------------------------------------------------------
   // peripheral gating select
   // ------------------------------------------------------------
   assign auto_gate = run_q[scd_pkg::AUTO_GATE_BIT];

   always_comb begin
      gate_d = gate_run_q;
      if (auto_gate) begin
         // [RULE1] sleep sets used when auto gating
         if (pwr_mode == scd_pkg::SCD_SLEEP) begin
            gate_d = gate_slp_q;
         end else if (pwr_mode == scd_pkg::SCD_DEEP) begin
            gate_d = gate_dsl_q;
         end
      end
   end

   // [RULE2] run set otherwise, registered
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gate_q <= GATE_W'(scd_pkg::GATE_RESET);
         mode_q <= scd_pkg::SCD_RUN;
      end else begin
         gate_q <= gate_d;
         mode_q <= pwr_mode;
      end
   end
   assign periph_clk_en = gate_q;

   // ------------------------------------------------------------
   // system divisor select
   // ------------------------------------------------------------
   // bypass clear means the pll drives the divider
   assign pll_used = !run_q[scd_pkg::BYPASS_BIT];

   // [RULE8] second config overrides divisor
   assign prog_div = sec_q[scd_pkg::SEC_EN_BIT]
      ? sec_q[scd_pkg::SYS_DIVISOR_HI:scd_pkg::SYS_DIVISOR_LO]
      : run_q[scd_pkg::SYS_DIVISOR_HI:scd_pkg::SYS_DIVISOR_LO];

   always_comb begin
      // [RULE5] clamp to minimum with pll
      // [RULE6] raw divisor without pll
      if (pll_used && prog_div < MIN_SYS_DIV) begin
         div_d = MIN_SYS_DIV;
      end else begin
         div_d = prog_div;
      end
      // [RULE7] pll forces the divider
      use_div_d = run_q[scd_pkg::DIV_EN_BIT] || pll_used;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_q <= scd_pkg::RUN_RESET[scd_pkg::SYS_DIVISOR_HI:scd_pkg::SYS_DIVISOR_LO];
         use_div_q <= 1'b0;
         pll_q <= 1'b0;
         freq_q <= OSC_MHZ;
      end else begin
         div_q <= div_d;
         use_div_q <= use_div_d;
         pll_q <= pll_used;
         // [RULE4] pll source taken as 200 MHz
         freq_q <= pll_used ? scd_pkg::PLL_VCO_MHZ : OSC_MHZ;
      end
   end
   assign sys_div_code = div_q;
   assign sys_use_div = use_div_q;
   assign pll_src = pll_q;
   assign src_freq_mhz = freq_q;

   // ------------------------------------------------------------
   // pwm predivider
   // ------------------------------------------------------------
   // [RULE9] enable and code feed predivider
   assign pwm_bus.en = run_q[scd_pkg::PWM_EN_BIT];
   assign pwm_bus.code = run_q[scd_pkg::PWM_DIVISOR_HI:scd_pkg::PWM_DIVISOR_LO];
   assign pwm_clk_en = pwm_bus.tick;
   assign pwm_div_on = run_q[scd_pkg::PWM_EN_BIT];

   scd_pwm_div u_pwm (
      .clk_sys(clk_sys),
      .rst(rst),
      .pwm(pwm_bus.div)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   gate_sleep_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
      auto_gate && pwr_mode == scd_pkg::SCD_SLEEP |=> gate_q == $past(gate_slp_q))
      else $error("sleep gating set not used");
   gate_deep_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
      auto_gate && pwr_mode == scd_pkg::SCD_DEEP |=> gate_q == $past(gate_dsl_q))
      else $error("deep-sleep gating set not used");
   gate_run_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
      pwr_mode == scd_pkg::SCD_RUN || !auto_gate |=> gate_q == $past(gate_run_q))
      else $error("run gating set not used");
   sys_divisor_reset_a: assert property (@(posedge clk_sys) // [RULE3]
      rst |=> run_q[scd_pkg::SYS_DIVISOR_HI:scd_pkg::SYS_DIVISOR_LO] == 4'hf)
      else $error("divisor reset value wrong");
   pll_freq_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
      pll_used ##1 pll_used |-> freq_q == 8'hc8)
      else $error("pll frequency not 200");
   div_clamp_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
      pll_used && prog_div < MIN_SYS_DIV |=> div_q == MIN_SYS_DIV)
      else $error("divisor not clamped");
   div_raw_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
      !pll_used |=> div_q == $past(prog_div))
      else $error("divisor altered without pll");
   div_force_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
      pll_used |=> use_div_q)
      else $error("divider not forced with pll");
   sec_select_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE8]
      sec_q[scd_pkg::SEC_EN_BIT] && !pll_used
      |=> div_q == $past(sec_q[scd_pkg::SYS_DIVISOR_HI:scd_pkg::SYS_DIVISOR_LO]))
      else $error("second divisor not used");
   pwm_reset_a: assert property (@(posedge clk_sys) // [RULE9]
      rst |=> !run_q[scd_pkg::PWM_EN_BIT]
         && run_q[scd_pkg::PWM_DIVISOR_HI:scd_pkg::PWM_DIVISOR_LO] == 3'h7)
      else $error("pwm fields reset wrong");
   pwm_div4_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE10]
      (pwm_bus.en && pwm_bus.code == 3'h1)[*8] ##0 pwm_clk_en
      |-> !$past(pwm_clk_en) && !$past(pwm_clk_en, 2) && !$past(pwm_clk_en, 3)
         && $past(pwm_clk_en, 4))
      else $error("pwm divide by four wrong");
   unmapped_err_a: assert property (@(posedge clk_sys) disable iff (rst)
      psel && penable && !hit |-> pslverr && pready)
      else $error("unmapped access not refused");

   // ------------------------------------------------------------
   // checks: register bus and remaining divisor cases
   // ------------------------------------------------------------
   // a refused write must not leak into the run or second config register
   wr_refuse_a: assert property (@(posedge clk_sys) disable iff (rst)
      psel && penable && pwrite && !hit |=> $stable(run_q) && $stable(sec_q))
      else $error("refused write changed a register");
   mapped_ok_a: assert property (@(posedge clk_sys) disable iff (rst)
      psel && penable && hit |-> !pslverr && pready)
      else $error("mapped access refused");
   // read data is only loaded in a read setup cycle
   rd_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      !(setup && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside setup");
   ro_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
      (run_q & ~scd_pkg::RUN_WMASK) == 32'h00000000
         && (sec_q & ~scd_pkg::SEC_WMASK) == 32'h00000000)
      else $error("read-only bits not zero");
   gate_idle_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
      auto_gate && pwr_mode == 2'b11 |=> gate_q == $past(gate_run_q))
      else $error("unused mode code not on run gating");
   div_plain_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
      !pll_used |=> use_div_q == $past(run_q[scd_pkg::DIV_EN_BIT]))
      else $error("divider enable bit not followed");
   osc_freq_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
      !pll_used ##1 !pll_used |-> freq_q == OSC_MHZ)
      else $error("oscillator frequency wrong");

   // ------------------------------------------------------------
   // coverage
   // ------------------------------------------------------------
   clamp_seen_c: cover property (@(posedge clk_sys) disable iff (rst)
      pll_used && prog_div < MIN_SYS_DIV);
   sec_seen_c: cover property (@(posedge clk_sys) disable iff (rst)
      sec_q[scd_pkg::SEC_EN_BIT]);
   deep_seen_c: cover property (@(posedge clk_sys) disable iff (rst)
      auto_gate && pwr_mode == scd_pkg::SCD_DEEP);
   pwm_on_c: cover property (@(posedge clk_sys) disable iff (rst)
      pwm_bus.en && pwm_clk_en);
   strobe_part_c: cover property (@(posedge clk_sys) disable iff (rst)
      wr_acc && pstrb != 4'hf);
endmodule

// file: tb.sv
// tb: self-checking bench for the clock divider control block
`timescale 1ns/1ps
module tb;
   // ------------------------------------------------------------
   // signals and instance
   // ------------------------------------------------------------
   localparam logic [3:0] MIN_DIV = 4'h5;
   localparam logic [7:0] OSC_FREQ = 8'h19;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'h0;
   logic [1:0] pwr_mode = 2'b00;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] periph_clk_en;
   logic [3:0] sys_div_code;
   logic sys_use_div;
   logic pll_src;
   logic [7:0] src_freq_mhz;
   logic pwm_clk_en;
   logic pwm_div_on;
   logic [32:0] exp_q[$];
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   scd_ctrl #(.GATE_W(32), .MIN_SYS_DIV(MIN_DIV), .OSC_MHZ(OSC_FREQ)) dut (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pwr_mode(pwr_mode), .periph_clk_en(periph_clk_en),
      .sys_div_code(sys_div_code), .sys_use_div(sys_use_div), .pll_src(pll_src),
      .src_freq_mhz(src_freq_mhz), .pwm_clk_en(pwm_clk_en), .pwm_div_on(pwm_div_on)
   );
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("mismatches=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // master holds the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask
   // expected answer is queued before the read is issued
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
      exp_q.push_back({err, d});
      apb(1'b0, a, 32'h00000000, 4'hf);
   endtask
   // ------------------------------------------------------------
   // read monitor and timeout
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      logic [32:0] e;
      if (psel && penable) begin
         check({31'h0, pready}, 32'h00000001);
      end
      if (psel && penable && pready && !pwrite) begin
         if (exp_q.size() == 0) begin
            check(32'hdead0000, 32'h00000000);
         end else begin
            e = exp_q.pop_front();
            check(prdata, e[31:0]);
            check({31'h0, pslverr}, {31'h0, e[32]});
         end
      end
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         finish_test();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] w, s, g0, g1, g2, ge;
      logic [3:0] d1, d2, pr, ef;
      logic byp, sec, den;
      int n, ratio;
      void'($urandom(32'hff9bc18d));
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check(sys_div_code, 4'hf);
      check({sys_use_div, pll_src}, 2'b00);
      check(src_freq_mhz, OSC_FREQ);
      check({pwm_clk_en, pwm_div_on}, 2'b10);
      // refused write must leave the run config at reset
      wr(12'h204, 32'hffffffff);
      rd(scd_pkg::ADDR_RUN_CFG, scd_pkg::RUN_RESET, 1'b0);
      rd(scd_pkg::ADDR_SEC_CFG, scd_pkg::SEC_RESET, 1'b0);
      rd(scd_pkg::ADDR_GATE_SLP, scd_pkg::GATE_RESET, 1'b0);
      rd(12'h200, 32'h00000000, 1'b1);
      // byte lanes update only the enabled byte
      wr(scd_pkg::ADDR_GATE_RUN, 32'h00000000);
      apb(1'b1, scd_pkg::ADDR_GATE_RUN, 32'hffffffff, 4'b0100);
      rd(scd_pkg::ADDR_GATE_RUN, 32'h00ff0000, 1'b0);
      g0 = $urandom;
      g1 = $urandom;
      g2 = $urandom;
      wr(scd_pkg::ADDR_GATE_RUN, g0);
      wr(scd_pkg::ADDR_GATE_SLP, g1);
      wr(scd_pkg::ADDR_GATE_DSL, g2);
      for (int a = 0; a < 2; a++) begin
         w = scd_pkg::RUN_RESET;
         w[scd_pkg::AUTO_GATE_BIT] = a[0];
         wr(scd_pkg::ADDR_RUN_CFG, w);
         for (int m = 0; m < 4; m++) begin
            pwr_mode <= m[1:0];
            repeat (4) @(posedge clk_sys);
            ge = (a == 1 && m == 1) ? g1 : (a == 1 && m == 2) ? g2 : g0;
            check(periph_clk_en, ge);
         end
      end
      pwr_mode <= 2'b00;
      for (int i = 0; i < 16; i++) begin
         byp = i[0];
         sec = i[1];
         den = i[2];
         d1 = (i < 8) ? MIN_DIV - 4'h1 : 4'($urandom);
         d2 = (i < 8) ? MIN_DIV - 4'(i[3]) : 4'($urandom);
         w = $urandom;
         w[scd_pkg::SYS_DIVISOR_HI:scd_pkg::SYS_DIVISOR_LO] = d1;
         w[scd_pkg::DIV_EN_BIT] = den;
         w[scd_pkg::BYPASS_BIT] = byp;
         w[scd_pkg::PWM_EN_BIT] = 1'b0;
         s = $urandom;
         s[scd_pkg::SEC_EN_BIT] = sec;
         s[26:23] = d2;
         wr(scd_pkg::ADDR_RUN_CFG, w);
         wr(scd_pkg::ADDR_SEC_CFG, s);
         pr = sec ? d2 : d1;
         ef = (!byp && pr < MIN_DIV) ? MIN_DIV : pr;
         repeat (3) @(posedge clk_sys);
         check(sys_div_code, ef);
         check(sys_use_div, den | !byp);
         check(pll_src, !byp);
         check(src_freq_mhz, byp ? OSC_FREQ : scd_pkg::PLL_VCO_MHZ);
         rd(scd_pkg::ADDR_RUN_CFG, w & scd_pkg::RUN_WMASK, 1'b0);
         rd(scd_pkg::ADDR_SEC_CFG, s & scd_pkg::SEC_WMASK, 1'b0);
         rd(scd_pkg::ADDR_STATUS, {16'h0000, (byp ? OSC_FREQ : scd_pkg::PLL_VCO_MHZ),
            2'b00, !byp, den | !byp, ef}, 1'b0);
      end
      wr(scd_pkg::ADDR_SEC_CFG, scd_pkg::SEC_RESET);
      for (int c = 0; c < 8; c++) begin
         w = scd_pkg::RUN_RESET;
         w[scd_pkg::PWM_EN_BIT] = 1'b1;
         w[scd_pkg::PWM_DIVISOR_HI:scd_pkg::PWM_DIVISOR_LO] = c[2:0];
         wr(scd_pkg::ADDR_RUN_CFG, w);
         ratio = (c < 5) ? (2 << c) : 64;
         repeat (4) @(posedge clk_sys);
         check(pwm_div_on, 1'b1);
         n = 0;
         while (pwm_clk_en !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
         end
         n = 0;
         do begin
            @(posedge clk_sys);
            n++;
         end while (pwm_clk_en !== 1'b1 && n < 200);
         check(n, ratio);
         @(posedge clk_sys);
         check(pwm_clk_en, 1'b0);
      end
      // undivided pwm clock holds its enable high
      wr(scd_pkg::ADDR_RUN_CFG, scd_pkg::RUN_RESET);
      repeat (3) @(posedge clk_sys);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_sys);
         check({pwm_clk_en, pwm_div_on}, 2'b10);
      end
      repeat (3) @(posedge clk_sys);
      check(exp_q.size(), 0);
      finish_test();
   end
endmodule
